// File: pdc_pkg.sv
// constants and types shared by the pwm output stage
package pdc_pkg;

    // register byte offsets
    localparam logic [7:0] PDC_OFF_CTRL = 8'h00;
    localparam logic [7:0] PDC_OFF_CFG = 8'h04;
    localparam logic [7:0] PDC_OFF_DEAD = 8'h08;
    localparam logic [7:0] PDC_OFF_MAN = 8'h0c;
    localparam logic [7:0] PDC_OFF_STAT = 8'h10;

    // control register fields
    localparam int PDC_CTRL_EN_BIT = 0;
    localparam int PDC_CTRL_MAN_BIT = 1;
    localparam int PDC_CTRL_METH_LO = 2;
    localparam int PDC_CTRL_POL_LO = 4;

    // write-once configuration fields
    localparam int PDC_CFG_UNPAIRED_BIT = 0;
    localparam int PDC_CFG_TOPINV_BIT = 1;
    localparam int PDC_CFG_BOTINV_BIT = 2;

    // status register fields
    localparam int PDC_STAT_OUT_LO = 0;
    localparam int PDC_STAT_SEL_LO = 6;
    localparam int PDC_STAT_SENSE_LO = 9;
    localparam int PDC_STAT_CFGLK_BIT = 12;
    localparam int PDC_STAT_DEADLK_BIT = 13;

    // reset values
    localparam logic [6:0] PDC_CTRL_RESET = 7'h00;
    localparam logic [2:0] PDC_CFG_RESET = 3'h0;
    localparam logic [7:0] PDC_DEAD_RESET = 8'hff;
    localparam logic [5:0] PDC_MAN_RESET = 6'h00;

    // correction method field
    typedef enum logic [1:0] {
        PDC_METH_SW0 = 2'h0,
        PDC_METH_SW1 = 2'h1,
        PDC_METH_PIN_DEAD = 2'h2,
        PDC_METH_PIN_MID = 2'h3
    } pdc_meth_t;

endpackage

// File: pdc_dead_gen.sv
// dead-time generator for one complementary pair
`timescale 1ns/100ps
module pdc_dead_gen
    import pdc_pkg::*;
#(
    parameter int DT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_i,
    input wire logic [DT_W-1:0] dead_i,
    output logic top_o,
    output logic bot_o
);

    logic prev_ff;
    logic [DT_W-1:0] cnt_ff;
    logic top_ff;
    logic bot_ff;

    // every edge of the input reloads the counter and blanks both sides
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= 1'b0;
            cnt_ff <= '0;
            top_ff <= 1'b0;
            bot_ff <= 1'b0;
        end else if (in_i != prev_ff) begin
            prev_ff <= in_i;
            cnt_ff <= dead_i;
            top_ff <= 1'b0;
            bot_ff <= 1'b0;
        end else if (cnt_ff > 1) begin
            cnt_ff <= cnt_ff - 1'b1;
        end else begin
            cnt_ff <= '0;
            top_ff <= prev_ff;
            bot_ff <= ~prev_ff;
        end
    end

    assign top_o = top_ff;
    assign bot_o = bot_ff;

    a_pair_exclusive: assert property (@(posedge pclk) disable iff (!presetn) !(top_ff && bot_ff))
        else $error("top and bottom active together");
    a_dead_blank: assert property (@(posedge pclk) disable iff (!presetn)
        (in_i != prev_ff && dead_i >= 8'd3) |=> (!top_ff && !bot_ff)[*3])
        else $error("dead-time blanking too short");
    a_dead_end: assert property (@(posedge pclk) disable iff (!presetn)
        (in_i != prev_ff && dead_i == 8'd2) ##1 (in_i == prev_ff) ##1 (in_i == prev_ff) |=> (top_ff || bot_ff))
        else $error("dead-time did not end on time");

endmodule

// File: pdc_out_stage.sv
// pwm output stage: pairing, dead-time, top/bottom correction, polarity, apb registers
// What this block does
// - six outputs run independently or as three complementary pairs per the unpaired option.
// - in paired mode one selected value register drives both outputs of a pair.
// - in independent mode each output follows its own value register.
// - dead-time length is an 8-bit count of cpu clocks with both outputs off.
// - dead-time counts undivided clocks, unaffected by the period prescaler.
// - selected odd or even generator output, or odd manual bit under manual control, feeds dead-time.
// - each dead-time input edge blanks both outputs for the dead-time first.
// - in paired mode bottom comes from top and dead-time; top and bottom never active together.
// - manual odd bits drive tops; in paired mode even bits gate bottoms only as complements, in independent mode they drive bottoms.
// - sensed polarity 0 selects the odd value register, 1 selects the even one.
// - method 00 or 01 selects by software polarity bits, ignoring sense pins.
// - method 10 latches sense pins while both pair outputs are off.
// - method 11 latches at half cycle (center) or cycle end (edge).
// - top/bottom selection applies only in complementary operation.
// - top/bottom decision is made at the start of each period.
// - polarity bits and sensed values are buffered; changes apply next period.
// - correction method field is used unbuffered, immediately.
// - first enable with pin correction uses value registers 1, 3 and 5.
// - tops 1,3,5 use high side invert, bottoms 2,4,6 low side invert.
// - positive polarity drives active high, negative polarity drives active low.
// - both invert options sit in a configuration register written only once.
// - write-once dead-time register resets to all ones.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module pdc_out_stage
    import pdc_pkg::*;
#(
    parameter int NPAIR = 3,
    parameter int DT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2*NPAIR-1:0] gen_pwm,
    input wire logic period_start,
    input wire logic half_cycle,
    input wire logic edge_mode,
    input wire logic [NPAIR-1:0] current_sense_pin,
    output logic [2*NPAIR-1:0] pwm_out,
    output logic [NPAIR-1:0] value_sel_bottom
);

    ////////////////////////////////////////////////////////////////////////////
    // apb slave

    logic [6:0] ctrl_ff;
    logic [2:0] cfg_ff;
    logic cfg_lock_ff;
    logic [DT_W-1:0] dead_ff;
    logic dead_lock_ff;
    logic [2*NPAIR-1:0] man_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic nxt_slverr;
    logic wr_acc;
    logic [NPAIR-1:0] sel_ff;
    logic [NPAIR-1:0] sense_ff;
    logic [2*NPAIR-1:0] pwm_out_ff;

    // zero-wait answer: ready is raised for the access cycle that follows setup
    assign wr_acc = psel && penable && pready_ff && pwrite && pstrb[0];

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (paddr == PDC_OFF_CTRL) begin
            nxt_prdata[6:0] = ctrl_ff;
        end else if (paddr == PDC_OFF_CFG) begin
            nxt_prdata[2:0] = cfg_ff;
        end else if (paddr == PDC_OFF_DEAD) begin
            nxt_prdata[DT_W-1:0] = dead_ff;
        end else if (paddr == PDC_OFF_MAN) begin
            nxt_prdata[2*NPAIR-1:0] = man_ff;
        end else if (paddr == PDC_OFF_STAT) begin
            nxt_prdata[PDC_STAT_OUT_LO +: 2*NPAIR] = pwm_out_ff;
            nxt_prdata[PDC_STAT_SEL_LO +: NPAIR] = sel_ff;
            nxt_prdata[PDC_STAT_SENSE_LO +: NPAIR] = sense_ff;
            nxt_prdata[PDC_STAT_CFGLK_BIT] = cfg_lock_ff;
            nxt_prdata[PDC_STAT_DEADLK_BIT] = dead_lock_ff;
        end else begin
            nxt_slverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && !penable;
            pslverr_ff <= psel && !penable && nxt_slverr;
            if (psel && !penable && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= PDC_CTRL_RESET;
        end else if (wr_acc && paddr == PDC_OFF_CTRL) begin
            ctrl_ff <= pwdata[6:0];
        end
    end

    // write-once: a stray write must not flip gate polarity and short a leg
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= PDC_CFG_RESET;
            cfg_lock_ff <= 1'b0;
        end else if (wr_acc && paddr == PDC_OFF_CFG && !cfg_lock_ff) begin
            cfg_ff <= pwdata[2:0];
            cfg_lock_ff <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_ff <= PDC_DEAD_RESET;
            dead_lock_ff <= 1'b0;
        end else if (wr_acc && paddr == PDC_OFF_DEAD && !dead_lock_ff) begin
            dead_ff <= pwdata[DT_W-1:0];
            dead_lock_ff <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_ff <= PDC_MAN_RESET;
        end else if (wr_acc && paddr == PDC_OFF_MAN) begin
            man_ff <= pwdata[2*NPAIR-1:0];
        end
    end

    logic modulator_enable;
    logic manual_req;
    pdc_meth_t meth;
    logic [NPAIR-1:0] software_current_polarity;
    logic unpaired_channel_option;
    logic high_side_invert;
    logic low_side_invert;

    assign modulator_enable = ctrl_ff[PDC_CTRL_EN_BIT];
    assign manual_req = ctrl_ff[PDC_CTRL_MAN_BIT];
    assign meth = pdc_meth_t'(ctrl_ff[PDC_CTRL_METH_LO +: 2]);
    assign software_current_polarity = ctrl_ff[PDC_CTRL_POL_LO +: NPAIR];
    assign unpaired_channel_option = cfg_ff[PDC_CFG_UNPAIRED_BIT];
    assign high_side_invert = cfg_ff[PDC_CFG_TOPINV_BIT];
    assign low_side_invert = cfg_ff[PDC_CFG_BOTINV_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // sense pin synchronisers and enable edge

    logic [NPAIR-1:0] sync1_ff;
    logic [NPAIR-1:0] sync2_ff;
    logic [NPAIR-1:0] sync3_ff;
    logic [NPAIR-1:0] sense_filt_ff;
    logic en_prev_ff;
    logic en_rise;
    logic man_eff_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            sense_filt_ff <= '0;
        end else begin
            sync1_ff <= current_sense_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < NPAIR; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    sense_filt_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_ff <= 1'b0;
        end else begin
            en_prev_ff <= modulator_enable;
        end
    end

    assign en_rise = modulator_enable && !en_prev_ff;

    // manual control takes over at once but hands back only at a period start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_eff_ff <= 1'b0;
        end else if (manual_req) begin
            man_eff_ff <= 1'b1;
        end else if (period_start) begin
            man_eff_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per pair: sense latch, value select, dead-time, polarity

    logic [NPAIR-1:0] nxt_sense;
    logic [NPAIR-1:0] dt_top;
    logic [NPAIR-1:0] dt_bot;
    logic [NPAIR-1:0] top_act;
    logic [NPAIR-1:0] bot_act;
    logic sense_strobe;

    // the cycle end in edge mode coincides with the next period start
    assign sense_strobe = edge_mode ? period_start : half_cycle;

    genvar p;
    generate
        for (p = 0; p < NPAIR; p++) begin : g_pair
            logic dt_in;

            always_comb begin
                nxt_sense[p] = sense_ff[p];
                if (en_rise) begin
                    nxt_sense[p] = 1'b0;
                end else if (meth == PDC_METH_PIN_DEAD) begin
                    // no blanking at 0 or 100 percent, so the value holds
                    if (!dt_top[p] && !dt_bot[p] && !unpaired_channel_option) begin
                        nxt_sense[p] = sense_filt_ff[p];
                    end
                end else if (meth == PDC_METH_PIN_MID) begin
                    if (sense_strobe) begin
                        nxt_sense[p] = sense_filt_ff[p];
                    end
                end
            end

            // odd register is channel 2p, even register is channel 2p+1
            assign dt_in = man_eff_ff ? man_ff[2*p] :
                (sel_ff[p] ? gen_pwm[2*p+1] : gen_pwm[2*p]);

            pdc_dead_gen #(
                .DT_W(DT_W)
            ) u_dead (
                .pclk(pclk),
                .presetn(presetn),
                .in_i(dt_in),
                .dead_i(dead_ff),
                .top_o(dt_top[p]),
                .bot_o(dt_bot[p])
            );

            always_comb begin
                if (unpaired_channel_option) begin
                    top_act[p] = man_eff_ff ? man_ff[2*p] : gen_pwm[2*p];
                    bot_act[p] = man_eff_ff ? man_ff[2*p+1] : gen_pwm[2*p+1];
                end else begin
                    top_act[p] = dt_top[p];
                    bot_act[p] = dt_bot[p] && (!man_eff_ff || man_ff[2*p+1]);
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_ff <= '0;
        end else begin
            sense_ff <= nxt_sense;
        end
    end

    // selection is buffered per period so one register serves a whole period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_ff <= '0;
        end else if (unpaired_channel_option) begin
            sel_ff <= '0;
        end else if (en_rise && meth[1]) begin
            sel_ff <= '0;
        end else if (period_start) begin
            sel_ff <= meth[1] ? nxt_sense : software_current_polarity;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out_ff <= '0;
        end else begin
            for (int i = 0; i < NPAIR; i++) begin
                pwm_out_ff[2*i] <= top_act[i] ^ high_side_invert;
                pwm_out_ff[2*i+1] <= bot_act[i] ^ low_side_invert;
            end
        end
    end

    assign pwm_out = pwm_out_ff;
    assign value_sel_bottom = sel_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_cfg_write_once: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_lock_ff) |-> $stable(cfg_ff))
        else $error("configuration changed after its single write");

    a_dead_write_once: assert property (@(posedge pclk) disable iff (!presetn)
        !dead_lock_ff |-> dead_ff == 8'hff)
        else $error("dead-time not all ones before first write");

    a_sel_at_start: assert property (@(posedge pclk) disable iff (!presetn)
        (sel_ff != $past(sel_ff)) |-> ($past(period_start) || $past(en_rise) || $past(unpaired_channel_option)))
        else $error("value select changed mid period");

    a_sw_select: assert property (@(posedge pclk) disable iff (!presetn)
        (period_start && !meth[1] && !unpaired_channel_option && !en_rise) |=>
        sel_ff == $past(software_current_polarity))
        else $error("software polarity not used for selection");

    a_first_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (en_rise && meth[1] && !period_start) |=> (sel_ff == '0 && sense_ff == '0))
        else $error("first enable did not select odd registers");

    a_unpaired_channel_option_no_sel: assert property (@(posedge pclk) disable iff (!presetn)
        $past(unpaired_channel_option) |-> sel_ff == '0)
        else $error("selection applied in independent operation");

    a_unpaired_channel_option_pass: assert property (@(posedge pclk) disable iff (!presetn)
        (unpaired_channel_option && !man_eff_ff) |=>
        pwm_out_ff[0] == ($past(gen_pwm[0]) ^ $past(high_side_invert)))
        else $error("independent output not passed straight through");

    a_pins_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        !unpaired_channel_option && $past(!unpaired_channel_option) |->
        !((pwm_out_ff[0] ^ $past(high_side_invert)) && (pwm_out_ff[1] ^ $past(low_side_invert))))
        else $error("pair 1 pins active together");

    a_meth_mid_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (meth == PDC_METH_PIN_MID && sense_strobe && !en_rise) |=> sense_ff == $past(sense_filt_ff))
        else $error("sense value not latched at strobe");

endmodule

// File: pdc_drv_model.sv
// gate driver and phase current sense model for the pwm output stage
`timescale 1ns/100ps
module pdc_drv_model (
    input wire logic pclk,
    input wire logic [5:0] pwm_out,
    input wire logic inv_top,
    input wire logic inv_bot,
    input wire logic paired,
    input wire logic [2:0] phase_neg,
    output logic [2:0] current_sense_pin,
    output int overlap_cnt
);
    logic [5:0] act;
    assign act = pwm_out ^ {3{inv_bot, inv_top}};
    initial current_sense_pin = 3'h0;
    initial overlap_cnt = 0;
    // pin high means negative phase current, changed on the edge like a real comparator
    always @(posedge pclk) begin
        current_sense_pin <= phase_neg;
    end
    // both switches of one leg on would short the bus
    always @(posedge pclk) begin
        for (int p = 0; p < 3; p++) begin
            if (paired && act[2*p] && act[2*p+1]) begin
                overlap_cnt <= overlap_cnt + 1;
            end
        end
    end
endmodule

// File: tb.sv
// self-checking testbench for the pwm output stage
`timescale 1ns/100ps
module tb;
    import pdc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic period_start, half_cycle, edge_mode, inv_top, inv_bot, paired;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [5:0] gen_pwm, pwm_out;
    logic [2:0] current_sense_pin, value_sel_bottom, phase_neg;
    int failures, checked, overlap_cnt;

    pdc_out_stage dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gen_pwm(gen_pwm), .period_start(period_start), .half_cycle(half_cycle),
        .edge_mode(edge_mode), .current_sense_pin(current_sense_pin), .pwm_out(pwm_out),
        .value_sel_bottom(value_sel_bottom));
    pdc_drv_model drv_u (.pclk(pclk), .pwm_out(pwm_out), .inv_top(inv_top), .inv_bot(inv_bot),
        .paired(paired), .phase_neg(phase_neg), .current_sense_pin(current_sense_pin),
        .overlap_cnt(overlap_cnt));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; holds everything until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    function logic [31:0] ctl(input logic en, input logic man, input logic [1:0] m, input logic [2:0] pol);
        return {25'h0, pol, m, man, en};
    endfunction

    task pulse(input logic half);
        @(posedge pclk);
        if (half) begin
            half_cycle <= 1'b1;
        end else begin
            period_start <= 1'b1;
        end
        @(posedge pclk);
        half_cycle <= 1'b0;
        period_start <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    task do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // pair 0 with bottom inverted: blanked pins read 2'b10
    task dead_edge(input logic v, input logic [1:0] fin);
        int n;
        n = 0;
        @(posedge pclk);
        gen_pwm[0] <= v;
        repeat (2) @(posedge pclk);
        #1;
        while (pwm_out[1:0] === 2'b10 && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(n, 3);
        chk(pwm_out[1:0], fin);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rdc(PDC_OFF_CTRL, 32'h0);
        rdc(PDC_OFF_DEAD, 32'hff);
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1'b1);
        wr(PDC_OFF_CFG, 32'h4);
        wr(PDC_OFF_CFG, 32'h3);
        rdc(PDC_OFF_CFG, 32'h4);
        inv_bot <= 1'b1;
        paired <= 1'b1;
        wr(PDC_OFF_DEAD, 32'h3);
        wr(PDC_OFF_DEAD, 32'h5);
        rdc(PDC_OFF_DEAD, 32'h3);
        rdc(PDC_OFF_STAT, 32'h3000);
        repeat (300) @(posedge pclk);
        $display("test regs done");
    endtask

    task t_dead;
        dead_edge(1'b1, 2'b11);
        dead_edge(1'b0, 2'b00);
        @(posedge pclk);
        gen_pwm[1] <= 1'b1;
        repeat (8) @(posedge pclk);
        #1;
        chk(pwm_out, 6'h00);
        $display("test dead done");
    endtask

    task t_sense;
        wr(PDC_OFF_CTRL, ctl(1'b0, 1'b0, 2'h3, 3'h0));
        phase_neg <= 3'h7;
        edge_mode <= 1'b1;
        repeat (6) @(posedge pclk);
        pulse(1'b0);
        wr(PDC_OFF_CTRL, ctl(1'b1, 1'b0, 2'h2, 3'h0));
        repeat (2) @(posedge pclk);
        #1;
        chk(value_sel_bottom, 3'h0);
        repeat (20) @(posedge pclk);
        dead_edge(1'b1, 2'b11);
        pulse(1'b0);
        chk(value_sel_bottom, 3'h1);
        wr(PDC_OFF_CTRL, ctl(1'b1, 1'b0, 2'h3, 3'h0));
        phase_neg <= 3'h2;
        repeat (6) @(posedge pclk);
        pulse(1'b0);
        chk(value_sel_bottom, 3'h2);
        @(posedge pclk);
        edge_mode <= 1'b0;
        phase_neg <= 3'h4;
        repeat (6) @(posedge pclk);
        pulse(1'b1);
        phase_neg <= 3'h1;
        repeat (6) @(posedge pclk);
        pulse(1'b0);
        chk(value_sel_bottom, 3'h4);
        for (int m = 0; m < 2; m++) begin
            phase_neg <= 3'h2;
            wr(PDC_OFF_CTRL, ctl(1'b1, 1'b0, m[1:0], 3'h5));
            pulse(1'b0);
            chk(value_sel_bottom, 3'h5);
            wr(PDC_OFF_CTRL, ctl(1'b1, 1'b0, m[1:0], 3'h3));
            repeat (3) @(posedge pclk);
            chk(value_sel_bottom, 3'h5);
            pulse(1'b0);
            chk(value_sel_bottom, 3'h3);
        end
        $display("test sense done");
    endtask

    task t_manual;
        wr(PDC_OFF_MAN, 32'h01);
        wr(PDC_OFF_CTRL, ctl(1'b1, 1'b1, 2'h0, 3'h3));
        repeat (12) @(posedge pclk);
        chk(pwm_out, 6'h2b);
        wr(PDC_OFF_MAN, 32'h02);
        repeat (12) @(posedge pclk);
        chk(pwm_out, 6'h28);
        wr(PDC_OFF_MAN, 32'h00);
        repeat (12) @(posedge pclk);
        chk(pwm_out, 6'h2a);
        $display("test manual done");
    endtask

    task t_unpaired_channel_option;
        logic [5:0] pat [2];
        pat = '{6'h2c, 6'h13};
        paired <= 1'b0;
        inv_top <= 1'b1;
        inv_bot <= 1'b0;
        wr(PDC_OFF_CFG, 32'h3);
        wr(PDC_OFF_CFG, 32'h0);
        rdc(PDC_OFF_CFG, 32'h3);
        wr(PDC_OFF_CTRL, ctl(1'b1, 1'b0, 2'h0, 3'h7));
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            gen_pwm <= pat[i];
            @(posedge pclk);
            #1;
            chk(pwm_out, pat[i] ^ 6'h15);
        end
        pulse(1'b0);
        chk(value_sel_bottom, 3'h0);
        $display("test unpaired_channel_option done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        give_verdict;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        gen_pwm = 6'h00;
        period_start = 1'b0;
        half_cycle = 1'b0;
        edge_mode = 1'b0;
        phase_neg = 3'h0;
        inv_top = 1'b0;
        inv_bot = 1'b0;
        paired = 1'b0;
        failures = 0;
        checked = 0;
        do_reset;
        t_regs;
        t_dead;
        t_sense;
        t_manual;
        chk(overlap_cnt, 0);
        do_reset;
        t_unpaired_channel_option;
        give_verdict;
    end
endmodule
